// file: src/umso_pkg.sv
`default_nettype none
package umso_pkg;

   // instruction cycle phases, one clock each
   typedef enum logic [3:0] {
      PH_DECODE  = 4'b0001,
      PH_READ    = 4'b0010,
      PH_PROCESS = 4'b0100,
      PH_WRITE   = 4'b1000
   } umso_phase_t;

   // decoded operation, one-hot
   typedef enum logic [3:0] {
      OP_NONE     = 4'b0001,
      OP_MUL_LIT  = 4'b0010,
      OP_MUL_FILE = 4'b0100,
      OP_STORE    = 4'b1000
   } umso_op_t;

   // opcode patterns
   localparam logic [7:0] MUL_LIT_OPCODE  = 8'h0d;
   localparam logic [6:0] MUL_FILE_OPCODE = 7'h01;
   localparam logic [6:0] STORE_OPCODE    = 7'h37;

   // instruction field positions
   localparam int OPC_HI_MSB   = 15;
   localparam int OPC_HI_LSB   = 8;
   localparam int OPC_BANK_LSB = 9;
   localparam int BANK_BIT_POS = 8;

   // access bank split and indexed window limit
   localparam logic [7:0] ACCESS_SPLIT     = 8'h60;
   localparam logic [7:0] INDEX_LIMIT      = 8'h5f;
   localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

   // values after reset
   localparam logic [7:0]  BYTE_RST  = 8'h00;
   localparam logic [11:0] ADDR_RST  = 12'h000;
   localparam logic [15:0] INSTR_RST = 16'h0000;

endpackage : umso_pkg
`default_nettype wire

// file: src/umso_umul8.sv
`default_nettype none
module umso_umul8 (
   input  wire logic [7:0]  a,
   input  wire logic [7:0]  b,
   output logic      [15:0] p
);
   import umso_pkg::*;

   logic [15:0] acc [0:8];

   assign acc[0] = 16'h0000;

   // shift-and-add, one partial product per multiplier bit
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_pp
         assign acc[i+1] = acc[i] + (b[i] ? ({8'h00, a} << i) : 16'h0000);
      end
   endgenerate

   assign p = acc[8];

endmodule // umso_umul8
`default_nettype wire

// file: src/umso_exec.sv
`default_nettype none
module umso_exec (
   input  wire logic                  CLK,
   input  wire logic                  RST_B,
   input  wire logic                  INSTR_VALID,
   input  wire logic [15:0]           INSTR,
   input  wire logic [7:0]            W_VALUE,
   input  wire logic [3:0]            BANK_SELECT,
   input  wire logic                  EXT_SET_EN,
   input  wire logic [11:0]           INDEX_BASE,
   input  wire logic [7:0]            FILE_RDATA,
   output var umso_pkg::umso_phase_t  PHASE,
   output logic      [11:0]           FILE_ADDR,
   output logic                       FILE_RD,
   output logic                       FILE_WR,
   output logic      [7:0]            FILE_WDATA,
   output logic      [7:0]            PRODUCT_HIGH_BYTE,
   output logic      [7:0]            PRODUCT_LOW_BYTE,
   output logic                       PRODUCT_WE,
   output logic                       INSTR_DONE
);
   import umso_pkg::*;

   umso_phase_t phase_reg;
   umso_phase_t phase_next;
   umso_op_t    op_reg;
   umso_op_t    op_dec;
   logic [7:0]  w_reg;
   logic [7:0]  opnd_reg;
   logic [11:0] addr_reg;
   logic        rd_reg;
   logic        wr_reg;
   logic [7:0]  wdata_reg;
   logic [7:0]  prod_hi_reg;
   logic [7:0]  prod_lo_reg;
   logic        prod_we_reg;
   logic        done_reg;
   logic [15:0] product;
   logic [7:0]  lit_reg;

   wire [7:0]  f_field   = INSTR[7:0];
   wire        bank_bit  = INSTR[BANK_BIT_POS];
   wire        is_mul_lit  = INSTR[OPC_HI_MSB:OPC_HI_LSB] == MUL_LIT_OPCODE;
   wire        is_mul_file = INSTR[OPC_HI_MSB:OPC_BANK_LSB] == MUL_FILE_OPCODE;
   wire        is_store    = INSTR[OPC_HI_MSB:OPC_BANK_LSB] == STORE_OPCODE;
   wire        is_mul      = (op_reg == OP_MUL_LIT) || (op_reg == OP_MUL_FILE);

   assign op_dec = !INSTR_VALID ? OP_NONE :
                   is_mul_lit   ? OP_MUL_LIT :
                   is_mul_file  ? OP_MUL_FILE :
                   is_store     ? OP_STORE : OP_NONE;

   wire [11:0] access_addr = (f_field < ACCESS_SPLIT) ? {ACCESS_LOW_BANK, f_field}
                                                       : {ACCESS_HIGH_BANK, f_field};
   wire        use_index   = EXT_SET_EN && (f_field <= INDEX_LIMIT);
   wire [11:0] index_addr  = INDEX_BASE + {4'h0, f_field};
   wire [11:0] banked_addr = {BANK_SELECT, f_field};
   wire [11:0] file_addr   = bank_bit  ? banked_addr :
                             use_index ? index_addr : access_addr;

   always_comb begin
      case (phase_reg)
         PH_DECODE:  phase_next = PH_READ;
         PH_READ:    phase_next = PH_PROCESS;
         PH_PROCESS: phase_next = PH_WRITE;
         PH_WRITE:   phase_next = PH_DECODE;
         default:    phase_next = PH_DECODE;
      endcase
   end

   umso_umul8 u_mul (
      .a (w_reg),
      .b (opnd_reg),
      .p (product)
   );

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         phase_reg <= PH_DECODE;
      end else begin
         phase_reg <= phase_next;
      end
   end

   // decode: latch op and resolved address, request a read for the file multiply
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         op_reg   <= OP_NONE;
         addr_reg <= ADDR_RST;
         rd_reg   <= 1'b0;
      end else if (phase_reg == PH_DECODE) begin
         op_reg   <= op_dec;
         addr_reg <= file_addr;
         rd_reg   <= (op_dec == OP_MUL_FILE);
      end else if (phase_reg == PH_READ) begin
         rd_reg   <= 1'b0;
      end
   end

   // operand read: working value and literal or file byte
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         w_reg    <= BYTE_RST;
         opnd_reg <= BYTE_RST;
      end else if (phase_reg == PH_READ) begin
         w_reg    <= W_VALUE;
         opnd_reg <= (op_reg == OP_MUL_FILE) ? FILE_RDATA : lit_reg;
      end
   end

   // literal is held from decode so a changing instruction bus cannot disturb it
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         lit_reg <= BYTE_RST;
      end else if (phase_reg == PH_DECODE) begin
         lit_reg <= f_field;
      end
   end

   // process: results show during the write phase
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         prod_hi_reg <= BYTE_RST;
         prod_lo_reg <= BYTE_RST;
         prod_we_reg <= 1'b0;
      end else if (phase_reg == PH_PROCESS) begin
         prod_we_reg <= is_mul;
         if (is_mul) begin
            // high byte and low byte split
            prod_hi_reg <= product[15:8];
            prod_lo_reg <= product[7:0];
         end
      end else begin
         prod_we_reg <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         wr_reg    <= 1'b0;
         wdata_reg <= BYTE_RST;
         done_reg  <= 1'b0;
      end else if (phase_reg == PH_PROCESS) begin
         wr_reg    <= (op_reg == OP_STORE);
         wdata_reg <= w_reg;
         done_reg  <= (op_reg != OP_NONE);
      end else begin
         wr_reg    <= 1'b0;
         done_reg  <= 1'b0;
      end
   end

   // no flag path: this block has no status output to disturb
   assign PHASE             = phase_reg;
   assign FILE_ADDR         = addr_reg;
   assign FILE_RD           = rd_reg;
   assign FILE_WR           = wr_reg;
   assign FILE_WDATA        = wdata_reg;
   assign PRODUCT_HIGH_BYTE = prod_hi_reg;
   assign PRODUCT_LOW_BYTE  = prod_lo_reg;
   assign PRODUCT_WE        = prod_we_reg;
   assign INSTR_DONE        = done_reg;

   lit_mult_a: assert property (@(posedge CLK) disable iff (!RST_B)
      (phase_reg == PH_DECODE && INSTR_VALID && is_mul_lit) |-> ##3
      ({PRODUCT_HIGH_BYTE, PRODUCT_LOW_BYTE} ==
       16'({8'h00, $past(W_VALUE, 2)} * {8'h00, $past(INSTR[7:0], 3)})))
      else $error("literal multiply product wrong");

   // product bytes only change on multiply
   prod_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
      ($changed(PRODUCT_HIGH_BYTE) || $changed(PRODUCT_LOW_BYTE)) |->
      PRODUCT_WE && phase_reg == PH_WRITE)
      else $error("product bytes changed outside a multiply");

   mul_we_a: assert property (@(posedge CLK) disable iff (!RST_B)
      (phase_reg == PH_DECODE && INSTR_VALID && (is_mul_lit || is_mul_file)) |->
      ##3 PRODUCT_WE ##1 !PRODUCT_WE)
      else $error("multiply did not write the product pair once");

   // file product and no operand write
   file_mult_a: assert property (@(posedge CLK) disable iff (!RST_B)
      (phase_reg == PH_DECODE && INSTR_VALID && is_mul_file) |-> ##1 FILE_RD
      ##1 !FILE_WR ##1 (!FILE_WR &&
      {PRODUCT_HIGH_BYTE, PRODUCT_LOW_BYTE} ==
      16'({8'h00, $past(W_VALUE, 2)} * {8'h00, $past(FILE_RDATA, 2)})))
      else $error("file multiply product wrong or operand written");

   bank_addr_a: assert property (@(posedge CLK) disable iff (!RST_B)
      (phase_reg == PH_DECODE && INSTR_VALID && (is_mul_file || is_store) && bank_bit)
      |=> FILE_ADDR == {$past(BANK_SELECT), $past(INSTR[7:0])})
      else $error("banked file address wrong");

   index_addr_a: assert property (@(posedge CLK) disable iff (!RST_B)
      (phase_reg == PH_DECODE && INSTR_VALID && !bank_bit && EXT_SET_EN &&
       INSTR[7:0] <= INDEX_LIMIT)
      |=> FILE_ADDR == 12'($past(INDEX_BASE) + {4'h0, $past(INSTR[7:0])}))
      else $error("indexed file address wrong");

   store_write_a: assert property (@(posedge CLK) disable iff (!RST_B)
      (phase_reg == PH_DECODE && INSTR_VALID && is_store) |->
      ##3 (FILE_WR && !FILE_RD && FILE_WDATA == $past(W_VALUE, 2) && !PRODUCT_WE))
      else $error("store did not write the working value");

   cycle_done_a: assert property (@(posedge CLK) disable iff (!RST_B)
      INSTR_DONE |-> phase_reg == PH_WRITE ##1 (!INSTR_DONE && phase_reg == PH_DECODE))
      else $error("instruction did not finish in its write phase");

endmodule // umso_exec
`default_nettype wire

// file: bench/unsigned_multiply_and_store_ops_tb.sv
`default_nettype none
module unsigned_multiply_and_store_ops_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import umso_pkg::*;

   logic        clk, rst_b, instr_valid, ext_set_en;
   logic [15:0] instr;
   logic [7:0]  w_value, file_rdata, file_wdata, prod_hi, prod_lo;
   logic [3:0]  bank_select;
   logic [11:0] index_base, file_addr;
   umso_phase_t phase;
   logic        file_rd, file_wr, product_we, instr_done;
   logic [7:0]  mem [4096];
   int          n_errors, checked, cycles, seed;
   // model of the product pair: last entry is what the pair must hold
   int          prod_q[$];

   umso_exec umso_exec_i (.CLK(clk), .RST_B(rst_b), .INSTR_VALID(instr_valid), .INSTR(instr),
      .W_VALUE(w_value), .BANK_SELECT(bank_select), .EXT_SET_EN(ext_set_en),
      .INDEX_BASE(index_base), .FILE_RDATA(file_rdata), .PHASE(phase), .FILE_ADDR(file_addr),
      .FILE_RD(file_rd), .FILE_WR(file_wr), .FILE_WDATA(file_wdata),
      .PRODUCT_HIGH_BYTE(prod_hi), .PRODUCT_LOW_BYTE(prod_lo), .PRODUCT_WE(product_we),
      .INSTR_DONE(instr_done));

   // data memory answers combinationally and takes writes like the real file
   assign file_rdata = mem[file_addr];
   always @(posedge clk) if (file_wr === 1'b1) mem[file_addr] <= file_wdata;

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic check_phase(input umso_phase_t exp);
      checked++;
      if (phase !== exp) begin
         n_errors++;
         $display("unexpected phase: expected %b, seen %b", exp, phase);
      end
   endtask

   function automatic logic [11:0] exp_addr(input logic [15:0] ins, input logic [3:0] bs,
                                            input logic ext, input logic [11:0] ib);
      int f;
      f = int'(ins[7:0]);
      if (ins[8]) return {bs, ins[7:0]};
      if (ext && f <= 95) return 12'((int'(ib) + f) % 4096);
      return (f < 96) ? {ACCESS_LOW_BANK, ins[7:0]} : {ACCESS_HIGH_BANK, ins[7:0]};
   endfunction

   // outside decode everything but w_value in the read phase is noise, valid held high so a wrong sample shows
   task automatic drive_junk();
      instr       = 16'($random(seed));
      instr_valid = 1'b1;
      w_value     = 8'($random(seed));
      bank_select = 4'($random(seed));
      ext_set_en  = 1'($random(seed));
      index_base  = 12'($random(seed));
   endtask

   task automatic check_reset();
      prod_q.push_back(0);
      check_phase(PH_DECODE);                                          // idle at decode
      check_val("reset pulses", 16'h0, {file_rd, file_wr, product_we, instr_done});
      check_val("reset product", 16'h0, {prod_hi, prod_lo});          // cleared pair
   endtask

   // called just after the edge that enters a decode phase
   task automatic run_instr(input logic [15:0] ins, input logic vld, input logic [7:0] w,
                            input logic [3:0] bs, input logic ext, input logic [11:0] ib);
      int          kind;
      logic [11:0] a;
      logic [15:0] p;
      check_phase(PH_DECODE);                                          // cycle start
      check_val("done pulse", 16'h0, instr_done);                      // one cycle only
      drive_junk();
      instr = ins; instr_valid = vld; bank_select = bs; ext_set_en = ext; index_base = ib;
      kind = !vld ? 0 : ins[15:8] == 8'h0d ? 1 : ins[15:9] == 7'h01 ? 2 :
             ins[15:9] == 7'h37 ? 3 : 0;
      a = exp_addr(ins, bs, ext, ib);
      @(posedge clk); #2;
      drive_junk();
      w_value = w;
      check_phase(PH_READ);                                            // operand read
      check_val("file read", 16'(kind == 2), file_rd);                 // operand fetch
      if (kind > 1) check_val("file address", a, file_addr);           // banks
      p = 16'(int'(w) * int'(kind == 1 ? ins[7:0] : mem[a]));
      if (kind == 1 || kind == 2) prod_q.push_back(int'(p));
      @(posedge clk); #2;
      drive_junk();
      check_phase(PH_PROCESS);                                         // processing
      @(posedge clk); #2;
      drive_junk();
      check_phase(PH_WRITE);                                           // result write
      check_val("done", 16'(kind > 0), instr_done);                    // one cycle
      check_val("product strobe", 16'(kind == 1 || kind == 2), product_we);  // zero too
      check_val("file write", 16'(kind == 3), file_wr);                // kept
      check_val("product", 16'(prod_q[$]), {prod_hi, prod_lo});       // pair
      if (kind == 3) check_val("write data", w, file_wdata);           // copy of working
      if (kind == 3) check_val("write address", a, file_addr);         // target
      @(posedge clk); #2;
   endtask

   initial begin
      seed = 32'h745c1fba;
      n_errors = 0;
      checked = 0;
      cycles = 0;
      foreach (mem[i]) mem[i] = 8'($random(seed));
      rst_b = 1'b0; instr = 16'h0; instr_valid = 1'b0; w_value = 8'h0;
      bank_select = 4'h0; ext_set_en = 1'b0; index_base = 12'h0;
      repeat (20) @(posedge clk);
      #2;
      check_reset();
      rst_b = 1'b1;
      run_instr(16'h0dc4, 1'b1, 8'he2, 4'h0, 1'b0, 12'h0);            // literal multiply
      mem[12'h310] = 8'hb5;
      run_instr(16'h0310, 1'b1, 8'hc4, 4'h3, 1'b0, 12'h0);            // file mult
      run_instr(16'h0d00, 1'b1, 8'hff, 4'h0, 1'b1, 12'h0);            // zero product
      run_instr(16'h0d12, 1'b0, 8'h34, 4'h0, 1'b0, 12'h0);            // not valid
      run_instr(16'h0e55, 1'b1, 8'h34, 4'h0, 1'b0, 12'h0);            // foreign opcode
      // window edge 5Fh/60h, both bank bits, extended set off and on, index wrap
      for (int i = 0; i < 8; i++) begin
         run_instr({7'h37, i[0], i[1] ? 8'h60 : 8'h5f}, 1'b1, 8'(i * 37 + 5), 4'h9, i[2],
                   12'hfe0);                                           // store
         run_instr({7'h01, i[0], i[1] ? 8'h60 : 8'h5f}, 1'b1, 8'h3b, 4'h9, i[2],
                   12'hfe0);                                           // read back
      end
      for (int i = 0; i < 150; i++) begin
         case (2'($random(seed)))
            2'd0: instr = {8'h0d, 8'($random(seed))};
            2'd1: instr = {7'h01, 9'($random(seed))};
            2'd2: instr = {7'h37, 9'($random(seed))};
            default: instr = 16'($random(seed));
         endcase
         run_instr(instr, 3'($random(seed)) != 3'd0, 8'($random(seed)), 4'($random(seed)),
                   1'($random(seed)), 12'($random(seed)));             // mixed
      end
      // reset in mid instruction must abandon it cleanly
      instr = 16'h0d77; instr_valid = 1'b1;
      repeat (2) @(posedge clk);
      #2;
      rst_b = 1'b0;
      #1;
      check_reset();
      repeat (3) @(posedge clk);
      #2;
      rst_b = 1'b1;
      run_instr(16'h0dff, 1'b1, 8'hff, 4'h0, 1'b0, 12'h0);            // largest
      report_and_stop();
   end
endmodule // unsigned_multiply_and_store_ops_tb
`default_nettype wire
